// ---- hdl/lbc_defines.svh ----
// Constants of the byte link controller: offsets, fields, resets, codes, timing.
// Assumes inclusion by bare name from the design modules and the checker.
// Operation
// [RL1] Vector shows next source after clearing highest
// [RL2] Vector codes are multiples of four
// [RL3] CPU writes next byte after transmit-empty
// [RL4] Data read returns last received byte
// [RL5] Shift done loads shadow byte into shifter
// [RL6] Transmit-empty set after first bit sent
// [RL7] Complete byte copied to shadow, full set
// [RL8] Shadow overwritten after one byte time
// [RL9] Underrun sends two ones, then transmitter stops
// [RL10] Underrun abort reported as invalid symbol
// [RL11] Wait entered on WAIT with mode clear
// [RL12] Received message wakes wait mode, interrupts
// [RL13] Stop entered on STOP or WAIT+mode
// [RL14] Stop: bus activity wakes, non-maskable request
// [RL15] STOP entry: waking message not guaranteed
// [RL16] WAIT-stop: byte good only after EOF
// [RL17] Stop during reception: wake, settle, lose
// [RL18] Software finishes transmissions before low power
// [RL19] Data flags clear by vector then data access
// [RL20] Vector encodes sources by fixed priority
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LBC_OFS_VECTOR 2'h0
`define LBC_OFS_DATA 2'h1
`define LBC_OFS_CTRL 2'h2
`define LBC_OFS_STATUS 2'h3

// ----------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------
`define LBC_CTRL_IRQ_EN 0
`define LBC_CTRL_WAIT_CLK 1
`define LBC_CTRL_END_DATA 2
`define LBC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Vector codes by priority, lowest first
// ----------------------------------------------------------------
`define LBC_VEC_NONE 8'h00
`define LBC_SRC_EOF 1
`define LBC_SRC_RESP 2
`define LBC_SRC_RXFULL 3
`define LBC_SRC_TXEMPTY 4
`define LBC_SRC_ARB 5
`define LBC_SRC_CRC 6
`define LBC_SRC_INVALID 7
`define LBC_SRC_WAKE 8
`define LBC_VEC_SHIFT 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LBC_CLK_PERIOD_NS 25
`define LBC_SETTLE_NS 1600
`define LBC_SETTLE_CYC ((`LBC_SETTLE_NS + `LBC_CLK_PERIOD_NS - 1) / `LBC_CLK_PERIOD_NS)
`define LBC_UNDERRUN_ONES 2'h2

`endif

// ---- hdl/lbc_pkg.sv ----
// Types shared by the byte link controller modules.
// Assumes the constants header sits beside it.
package lbc_pkg;
  // ----------------------------------------------------------------
  // Power modes, Gray coded along run-wait-stop-settle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LBC_RUN = 2'h0,
    LBC_WAIT = 2'h1,
    LBC_STOP = 2'h3,
    LBC_SETTLE = 2'h2
  } lbc_mode_t;
endpackage

// ---- hdl/lbc_tx.sv ----
// Transmit shadow and shift register of the byte link controller.
// Assumes a symbol layer on mclk that asks for one bit per pulse.
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_tx import lbc_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // CPU side
  input wire logic loadStrobe,
  input wire logic [7:0] loadData,
  input wire logic endOfData,
  input wire logic inhibit,
  // Symbol layer side
  input wire logic txBitReq,
  output logic txBit,
  output logic txActive,
  // Events
  output logic txEmpty,
  output logic txUnderrun,
  output logic txDone
);
  logic [7:0] shiftReg, shiftNext; // Byte on the wire
  logic [7:0] shadowReg, shadowNext; // Next byte from the CPU
  logic shadowFullReg, shadowFullNext;
  logic busyReg, busyNext;
  logic uflowReg, uflowNext; // Sending the closing ones
  logic [2:0] bitCntReg, bitCntNext;
  logic [1:0] onesReg, onesNext;
  logic txBitReg, txBitNext;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    shiftNext = shiftReg;
    shadowNext = shadowReg;
    shadowFullNext = shadowFullReg;
    busyNext = busyReg;
    uflowNext = uflowReg;
    bitCntNext = bitCntReg;
    onesNext = onesReg;
    txBitNext = txBitReg;
    txEmpty = 1'b0;
    txUnderrun = 1'b0;
    txDone = 1'b0;
    // Idle: start with the first byte, never while inhibited
    if (!busyReg && shadowFullReg && !inhibit) begin
      shiftNext = shadowReg;
      shadowFullNext = 1'b0;
      busyNext = 1'b1;
      bitCntNext = 3'h0;
    end else if (busyReg && txBitReq) begin
      if (uflowReg) begin
        // Underrun: ones break the byte boundary, then stop (see [RL9])
        txBitNext = 1'b1;
        onesNext = onesReg + 2'h1;
        if (onesNext == `LBC_UNDERRUN_ONES) begin
          busyNext = 1'b0;
          uflowNext = 1'b0;
          txUnderrun = 1'b1;
        end
      end else begin
        txBitNext = shiftReg[7];
        shiftNext = {shiftReg[6:0], 1'b0};
        bitCntNext = bitCntReg + 3'h1;
        // First bit out frees the shadow (see [RL6])
        if (bitCntReg == 3'h0) begin
          txEmpty = 1'b1;
        end
        if (bitCntReg == 3'h7) begin
          if (shadowFullReg) begin
            // Double buffering hands the next byte over (see [RL5])
            shiftNext = shadowReg;
            shadowFullNext = 1'b0;
          end else if (endOfData) begin
            busyNext = 1'b0;
            txDone = 1'b1;
          end else begin
            // CPU stopped loading: abort path (see [RL9])
            uflowNext = 1'b1;
            onesNext = 2'h0;
          end
        end
      end
    end
    // CPU write lands last so it is never lost (see [RL3])
    if (loadStrobe) begin
      shadowNext = loadData;
      shadowFullNext = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= 8'h00;
      shadowReg <= 8'h00;
      shadowFullReg <= 1'b0;
      busyReg <= 1'b0;
      uflowReg <= 1'b0;
      bitCntReg <= 3'h0;
      onesReg <= 2'h0;
      txBitReg <= 1'b0;
    end else if (clkEn) begin
      shiftReg <= shiftNext;
      shadowReg <= shadowNext;
      shadowFullReg <= shadowFullNext;
      busyReg <= busyNext;
      uflowReg <= uflowNext;
      bitCntReg <= bitCntNext;
      onesReg <= onesNext;
      txBitReg <= txBitNext;
    end
  end

  // Nothing driven onto the bus while inhibited (see [RL11])
  assign txActive = busyReg && !inhibit;
  assign txBit = txBitReg;
endmodule

// ---- hdl/lbc_rx.sv ----
// Receive shift and shadow register of the byte link controller.
// Assumes a symbol layer on mclk delivering decoded bits and end-of-frame.
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_rx import lbc_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Symbol layer side
  input wire logic enable,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxEof,
  // CPU side
  output logic [7:0] rxShadow,
  output logic byteDone,
  output logic partialByte
);
  logic [7:0] shiftReg, shiftNext;
  logic [7:0] shadowReg, shadowNext;
  logic [2:0] cntReg, cntNext;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    shiftNext = shiftReg;
    shadowNext = shadowReg;
    cntNext = cntReg;
    byteDone = 1'b0;
    partialByte = 1'b0;
    if (!enable) begin
      // Clocks not stable: bits are dropped and the frame is lost
      cntNext = 3'h0;
    end else if (rxEof) begin
      // Frame ended off a byte boundary, e.g. an aborted sender
      partialByte = (cntReg != 3'h0);
      cntNext = 3'h0;
    end else if (rxBitValid) begin
      shiftNext = {shiftReg[6:0], rxBit};
      cntNext = cntReg + 3'h1;
      if (cntReg == 3'h7) begin
        // Shadow always takes the new byte, read or not (see [RL7], [RL8])
        shadowNext = {shiftReg[6:0], rxBit};
        byteDone = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= 8'h00;
      shadowReg <= 8'h00;
      cntReg <= 3'h0;
    end else if (clkEn) begin
      shiftReg <= shiftNext;
      shadowReg <= shadowNext;
      cntReg <= cntNext;
    end
  end

  assign rxShadow = shadowReg;
endmodule

// ---- hdl/lbc_link.sv ----
// Byte link controller data path, interrupt vector and low-power modes.
// Assumes a symbol layer on mclk, CPU WAIT/STOP pulses on mclk, and the
// raw bus activity pin from outside the clock domain.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_link import lbc_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // CPU power requests
  input wire logic cpuWait,
  input wire logic cpuStop,
  // Receive symbol layer
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxEof,
  input wire logic rxInResponse,
  input wire logic rxCrcError,
  input wire logic rxInvalid,
  input wire logic arbLost,
  // Transmit symbol layer
  input wire logic txBitReq,
  output logic txBit,
  output logic txActive,
  // Bus pin, active level high
  input wire logic busActivePin,
  // CPU interrupts
  output logic irq,
  output logic nmiReq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lbc_mode_t modeReg, modeNext; // Power mode
  logic [7:0] ctrlReg, ctrlNext; // Enables and end-of-data request
  logic [8:1] flagReg, flagNext; // Pending sources by priority
  logic armRxReg, armRxNext; // Vector read seen for a receive source
  logic armTxReg, armTxNext; // Vector read seen for transmit-empty
  logic eofSeenReg, eofSeenNext; // Bus idle since last end-of-frame
  logic goodWakeReg, goodWakeNext; // Wake byte will be received
  logic [6:0] settleReg, settleNext; // Clock restart wait
  logic nmiReg, nmiNext;
  logic [7:0] rdDataReg, rdDataNext;
  logic busSync1Reg, busSync2Reg, busPrevReg; // Pin synchroniser
  logic busRise;
  logic [7:0] vector;
  logic [3:0] topSrc;
  logic dataWr, dataRd, vecRd;
  logic txEmpty, txUnderrun, txDone;
  logic byteDone, partialByte;
  logic [7:0] rxShadow;
  logic rxEnable, txInhibit;

  // Strobe decode
  assign dataWr = regWr && (regAddr == `LBC_OFS_DATA);
  assign dataRd = regRd && (regAddr == `LBC_OFS_DATA);
  assign vecRd = regRd && (regAddr == `LBC_OFS_VECTOR);

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  lbc_tx u_tx (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .loadStrobe(dataWr),
    .loadData(regWrData),
    .endOfData(ctrlReg[`LBC_CTRL_END_DATA]),
    .inhibit(txInhibit),
    .txBitReq(txBitReq),
    .txBit(txBit),
    .txActive(txActive),
    .txEmpty(txEmpty),
    .txUnderrun(txUnderrun),
    .txDone(txDone)
  );

  lbc_rx u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .enable(rxEnable),
    .rxBitValid(rxBitValid),
    .rxBit(rxBit),
    .rxEof(rxEof),
    .rxShadow(rxShadow),
    .byteDone(byteDone),
    .partialByte(partialByte)
  );

  // ----------------------------------------------------------------
  // Bus pin synchroniser and wake edge
  // ----------------------------------------------------------------
  // Two flops before use; the edge detector compares the second flop with its delayed copy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busSync1Reg <= 1'b0;
      busSync2Reg <= 1'b0;
      busPrevReg <= 1'b0;
    end else if (clkEn) begin
      busSync1Reg <= busActivePin;
      busSync2Reg <= busSync1Reg;
      busPrevReg <= busSync2Reg;
    end
  end

  // Passive-to-active transition
  assign busRise = busSync2Reg && !busPrevReg;

  // ----------------------------------------------------------------
  // Priority encoder
  // ----------------------------------------------------------------
  // Highest pending source always shows, so clearing one reveals the next
  always_comb begin
    topSrc = 4'h0;
    for (int i = 1; i <= 8; i++) begin
      if (flagReg[i]) begin
        topSrc = 4'(i); // see [RL20], [RL1]
      end
    end
  end

  // Code is the source number times four (see [RL2])
  assign vector = {2'h0, topSrc, 2'h0};

  // ----------------------------------------------------------------
  // Low-power mode control
  // ----------------------------------------------------------------
  always_comb begin
    modeNext = modeReg;
    goodWakeNext = goodWakeReg;
    settleNext = settleReg;
    nmiNext = 1'b0;
    unique case (modeReg)
      LBC_RUN: begin
        if (cpuStop) begin
          // STOP entry: clocks restart on wake, message not kept (see [RL13], [RL15])
          modeNext = LBC_STOP;
          goodWakeNext = 1'b0;
        end else if (cpuWait && ctrlReg[`LBC_CTRL_WAIT_CLK]) begin
          // WAIT into stop: byte kept only after an end-of-frame (see [RL13], [RL16])
          modeNext = LBC_STOP;
          goodWakeNext = eofSeenReg; // see [RL17]
        end else if (cpuWait) begin
          modeNext = LBC_WAIT; // see [RL11]
        end
      end
      LBC_WAIT: begin
        // Clocks run; a cleanly ended message wakes us (see [RL12])
        if (rxEof && !partialByte && !rxCrcError && !rxInvalid) begin
          modeNext = LBC_RUN;
        end
      end
      LBC_STOP: begin
        if (busRise) begin
          // Any bus activity wakes with a non-maskable request (see [RL14])
          modeNext = LBC_SETTLE;
          nmiNext = 1'b1;
          settleNext = 7'h00;
        end
      end
      LBC_SETTLE: begin
        // Hold off until the clocks are stable (see [RL17])
        settleNext = settleReg + 7'h01;
        if (settleReg == 7'(`LBC_SETTLE_CYC - 1)) begin
          modeNext = LBC_RUN;
        end
      end
    endcase
  end

  // Receiver runs unless clocks are stopped or settling without a good wake
  assign rxEnable = (modeReg == LBC_RUN) || (modeReg == LBC_WAIT) || goodWakeReg;
  // No bus driving outside run mode (see [RL11])
  assign txInhibit = (modeReg != LBC_RUN);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg <= LBC_RUN;
      goodWakeReg <= 1'b0;
      settleReg <= 7'h00;
      nmiReg <= 1'b0;
    end else if (clkEn) begin
      modeReg <= modeNext;
      goodWakeReg <= goodWakeNext;
      settleReg <= settleNext;
      nmiReg <= nmiNext;
    end
  end

  // ----------------------------------------------------------------
  // Flags, control and register reads
  // ----------------------------------------------------------------
  always_comb begin
    flagNext = flagReg;
    ctrlNext = ctrlReg;
    armRxNext = armRxReg;
    armTxNext = armTxReg;
    eofSeenNext = eofSeenReg;
    rdDataNext = 8'h00;
    // Clears first; the sets below win in the same cycle
    if (vecRd) begin
      if (topSrc == 4'(`LBC_SRC_RESP) || topSrc == 4'(`LBC_SRC_RXFULL)) begin
        armRxNext = 1'b1; // see [RL19]
      end else if (topSrc == 4'(`LBC_SRC_TXEMPTY)) begin
        armTxNext = 1'b1; // see [RL19]
      end else if (topSrc != 4'h0) begin
        flagNext[topSrc] = 1'b0;
      end
    end
    if (dataRd && armRxReg) begin
      // Vector then data read clears receive sources (see [RL19])
      flagNext[`LBC_SRC_RESP] = 1'b0;
      flagNext[`LBC_SRC_RXFULL] = 1'b0;
      armRxNext = 1'b0;
    end
    if (dataWr && armTxReg) begin
      flagNext[`LBC_SRC_TXEMPTY] = 1'b0; // see [RL19]
      armTxNext = 1'b0;
    end
    if (regWr && regAddr == `LBC_OFS_CTRL) begin
      ctrlNext = {5'h00, regWrData[2:0]};
      if (regWrData[`LBC_CTRL_END_DATA]) begin
        flagNext[`LBC_SRC_TXEMPTY] = 1'b0; // see [RL19]
        armTxNext = 1'b0;
      end
    end
    // End-of-data request retires once the closing byte is out
    if (txDone || txUnderrun) begin
      ctrlNext[`LBC_CTRL_END_DATA] = 1'b0;
    end
    // Event sets
    if (rxEof) begin
      flagNext[`LBC_SRC_EOF] = 1'b1;
      eofSeenNext = 1'b1;
    end else if (rxBitValid) begin
      eofSeenNext = 1'b0;
    end
    if (byteDone) begin
      // Full flag marks a new byte in the shadow (see [RL7])
      if (rxInResponse) begin
        flagNext[`LBC_SRC_RESP] = 1'b1;
      end else begin
        flagNext[`LBC_SRC_RXFULL] = 1'b1;
      end
    end
    if (txEmpty && !ctrlReg[`LBC_CTRL_END_DATA]) begin
      flagNext[`LBC_SRC_TXEMPTY] = 1'b1; // see [RL6]
    end
    if (arbLost) begin
      flagNext[`LBC_SRC_ARB] = 1'b1;
    end
    if (rxCrcError) begin
      flagNext[`LBC_SRC_CRC] = 1'b1;
    end
    // Broken byte boundary, as left by an underrun abort (see [RL10])
    if (rxInvalid || partialByte) begin
      flagNext[`LBC_SRC_INVALID] = 1'b1;
    end
    if (modeReg == LBC_STOP && busRise) begin
      flagNext[`LBC_SRC_WAKE] = 1'b1; // see [RL14]
    end
    // Read data, valid in the cycle after the strobe
    if (regRd) begin
      unique case (regAddr)
        `LBC_OFS_VECTOR: rdDataNext = vector;
        `LBC_OFS_DATA: rdDataNext = rxShadow; // see [RL4]
        `LBC_OFS_CTRL: rdDataNext = ctrlReg;
        `LBC_OFS_STATUS: rdDataNext = {4'h0, goodWakeReg, eofSeenReg, modeReg};
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flagReg <= 8'h00;
      ctrlReg <= `LBC_CTRL_RESET;
      armRxReg <= 1'b0;
      armTxReg <= 1'b0;
      eofSeenReg <= 1'b1;
      rdDataReg <= 8'h00;
    end else if (clkEn) begin
      flagReg <= flagNext;
      ctrlReg <= ctrlNext;
      armRxReg <= armRxNext;
      armTxReg <= armTxNext;
      eofSeenReg <= eofSeenNext;
      rdDataReg <= rdDataNext;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData = rdDataReg;
  // Maskable request follows the enable bit (see [RL12])
  assign irq = ctrlReg[`LBC_CTRL_IRQ_EN] && (flagReg != 8'h00);
  assign nmiReq = nmiReg;
endmodule

// ---- test/lbc_link_checker.sv ----
// Port assertions for the byte link controller.
// Assumes clkEn is held high by the surroundings.
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_link_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Power, link and interrupt
  input wire logic cpuWait,
  input wire logic cpuStop,
  input wire logic txBitReq,
  input wire logic txBit,
  input wire logic txActive,
  input wire logic busActivePin,
  input wire logic nmiReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  a_rd_idle_zero: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_vec_aligned: assert property (regRd && regAddr == `LBC_OFS_VECTOR |=>
    regRdData[1:0] == 2'h0)
    else $error("vector not a multiple of four");
  a_vec_range: assert property (regRd && regAddr == `LBC_OFS_VECTOR |=>
    regRdData[7:6] == 2'h0 && regRdData[5:2] <= 4'h8)
    else $error("vector code out of range");
  // ----------------------------------------------------------------
  // Link and power
  // ----------------------------------------------------------------
  // A bit only moves on request, or once the transmitter has let go
  a_txbit_hold: assert property (!txBitReq |=> $stable(txBit) || !txActive)
    else $error("tx bit changed without request");
  a_wait_quiet: assert property (cpuWait |-> ##2 !txActive)
    else $error("transmitter active after wait");
  a_stop_quiet: assert property (cpuStop |-> ##2 !txActive)
    else $error("transmitter active after stop");
  a_nmi_pulse: assert property (nmiReq |=> !nmiReq)
    else $error("wake request longer than one cycle");
  // Pin passes a two-stage synchroniser, so the cause lies a few cycles back
  a_nmi_cause: assert property (nmiReq |->
    $past(busActivePin, 2) || $past(busActivePin, 3) || $past(busActivePin, 4))
    else $error("wake request without bus activity");
  c_nmi: cover property (nmiReq);
  c_tx: cover property ($rose(txActive));
  c_vec_tx: cover property (regRd && regAddr == 2'h0 ##1 regRdData == 8'h10);
endmodule

bind lbc_link lbc_link_checker chk (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
  .regRd(regRd), .regRdData(regRdData), .cpuWait(cpuWait), .cpuStop(cpuStop),
  .txBitReq(txBitReq), .txBit(txBit), .txActive(txActive),
  .busActivePin(busActivePin), .nmiReq(nmiReq));

// ---- test/lbc_bus_node.sv ----
// Model of the other bus nodes, seen through the symbol layer.
// Assumes the bench calls one task at a time per direction.
`timescale 1ns/1ps
module lbc_bus_node (
  // Clock
  input wire logic mclk,
  // Decoded receive symbols
  output logic rxBitValid,
  output logic rxBit,
  output logic rxEof,
  // Transmit symbols
  output logic txBitReq,
  input wire logic txBit,
  // Raw bus level, high is active
  output logic busActivePin
);
  initial begin
    rxBitValid = 1'b0;
    rxBit = 1'b0;
    rxEof = 1'b0;
    txBitReq = 1'b0;
    busActivePin = 1'b0;
  end
  // Bits MSB first; the line flips between bits so stale data is never held
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge mclk);
      rxBitValid <= 1'b1;
      rxBit <= b[i];
      @(posedge mclk);
      rxBitValid <= 1'b0;
      rxBit <= ~b[i];
    end
  endtask
  // End of frame, one pulse
  task automatic send_eof();
    @(posedge mclk);
    rxEof <= 1'b1;
    @(posedge mclk);
    rxEof <= 1'b0;
  endtask
  // Ask for n bits, shifting each answer in
  task automatic take_bits(input int n, inout logic [9:0] got);
    repeat (n) begin
      @(posedge mclk);
      txBitReq <= 1'b1;
      @(posedge mclk);
      txBitReq <= 1'b0;
      #1 got = {got[8:0], txBit};
    end
  endtask
  // Passive to active edge, held a few cycles
  task automatic wake();
    @(posedge mclk);
    busActivePin <= 1'b1;
    repeat (6) @(posedge mclk);
    busActivePin <= 1'b0;
  endtask
endmodule

// ---- test/lbc_link_tb.sv ----
// Self-checking bench of the byte link controller.
// Assumes the bus node model and the checker beside it.
`timescale 1ns/1ps
module lbc_link_tb import lbc_pkg::*;;
  logic mclk, rst_n, regWr, regRd, cpuWait, cpuStop, arbLost, crcErr;
  logic [1:0] regAddr;
  logic [7:0] regWrData, regRdData, b;
  logic rxBitValid, rxBit, rxEof, txBitReq, txBit, txActive, busActivePin, irq, nmiReq;
  logic [9:0] got;
  integer seed = 88;
  int mismatches = 0;
  int n_compared = 0;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  lbc_link uut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .cpuWait(cpuWait), .cpuStop(cpuStop), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .rxEof(rxEof), .rxInResponse(1'b0), .rxCrcError(crcErr), .rxInvalid(1'b0),
    .arbLost(arbLost), .txBitReq(txBitReq), .txBit(txBit), .txActive(txActive),
    .busActivePin(busActivePin), .irq(irq), .nmiReq(nmiReq));
  lbc_bus_node node (.mclk(mclk), .rxBitValid(rxBitValid), .rxBit(rxBit), .rxEof(rxEof),
    .txBitReq(txBitReq), .txBit(txBit), .busActivePin(busActivePin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] vec(input logic [3:0] s);
    return {2'b00, s, 2'b00};
  endfunction
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 q = regRdData;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic pw(input logic stp);
    @(posedge mclk);
    cpuStop <= stp;
    cpuWait <= ~stp;
    @(posedge mclk);
    cpuStop <= 1'b0;
    cpuWait <= 1'b0;
  endtask
  // Bounded wait: 0 tx on, 1 tx off, 2 wake request
  task automatic wait_on(input int s);
    int k = 0;
    while ((s == 0 ? txActive : s == 1 ? !txActive : nmiReq) !== 1'b1 && k < 40) begin
      @(posedge mclk);
      k++;
    end
    if (k == 40) begin
      mismatches++;
      stop_test();
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {regWr, regRd, cpuWait, cpuStop, regAddr, regWrData, arbLost, crcErr} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rc(2'h0, 8'hFF, vec(4'h0));
    rc(2'h2, 8'hFF, 8'h00);
    @(posedge mclk);
    {arbLost, crcErr} <= 2'h3;
    @(posedge mclk);
    {arbLost, crcErr} <= 2'h0;
    rc(2'h0, 8'hFF, vec(4'h6));
    rc(2'h0, 8'hFF, vec(4'h5));
    wr(2'h2, 8'h01);
    // Receive, then an unread byte overwritten by the next
    b = 8'($random(seed));
    node.send_bits(b, 8);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    rc(2'h0, 8'hFF, vec(4'h3));
    rc(2'h1, 8'hFF, b);
    rc(2'h0, 8'hFF, vec(4'h0));
    node.send_bits(8'h3C, 8);
    b = 8'($random(seed));
    node.send_bits(b, 8);
    rc(2'h1, 8'hFF, b);
    rc(2'h0, 8'hFF, vec(4'h3));
    rc(2'h1, 8'hFF, b);
    // Frame cut in mid-byte
    node.send_bits(b, 5);
    node.send_eof();
    rc(2'h0, 8'hFF, vec(4'h7));
    // Transmit over a pending receive flag, ended by end-of-data
    node.send_bits(8'hA5, 8);
    b = 8'($random(seed));
    wr(2'h1, b);
    wait_on(0);
    got = '0;
    node.take_bits(1, got);
    rc(2'h0, 8'hFF, vec(4'h4));
    wr(2'h2, 8'h05);
    rc(2'h0, 8'hFF, vec(4'h3));
    rc(2'h1, 8'hFF, 8'hA5);
    node.take_bits(7, got);
    chk(got[7:0], b);
    wait_on(1);
    // Two bytes, then underrun
    wr(2'h1, ~b);
    wait_on(0);
    got = '0;
    node.take_bits(1, got);
    rc(2'h0, 8'hFF, vec(4'h4));
    wr(2'h1, b);
    node.take_bits(7, got);
    chk(got[7:0], ~b);
    got = '0;
    node.take_bits(10, got);
    chk(got[9:2], b);
    chk({6'h00, got[1:0]}, 8'h03);
    repeat (2) @(posedge mclk);
    chk({7'h00, txActive}, 8'h00);
    // Wait mode, woken by a clean message
    pw(1'b0);
    rc(2'h3, 8'h03, 8'h01);
    b = 8'($random(seed));
    node.send_bits(b, 8);
    node.send_eof();
    repeat (2) @(posedge mclk);
    rc(2'h3, 8'h03, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rc(2'h1, 8'hFF, b);
    // Stop by STOP, then stop by WAIT with the clock mode bit
    pw(1'b1);
    rc(2'h3, 8'h03, 8'h03);
    fork
      node.wake();
      wait_on(2);
    join
    rc(2'h0, 8'hFF, vec(4'h8));
    rc(2'h3, 8'h03, 8'h02);
    repeat (70) @(posedge mclk);
    rc(2'h3, 8'h03, 8'h00);
    wr(2'h2, 8'h03);
    pw(1'b0);
    rc(2'h3, 8'h0B, 8'h0B);
    fork
      node.wake();
      wait_on(2);
    join
    repeat (70) @(posedge mclk);
    stop_test();
  end
endmodule
